// ===== inc/obc_defines.svh
// Constants for the option-byte configuration loader
`ifndef OBC_DEFINES_SVH
`define OBC_DEFINES_SVH

// ----------------------------------------------------------------
// Flash addresses of option bytes
// ----------------------------------------------------------------
`define OBC_ADDR_OPT0       16'h0080
`define OBC_ADDR_OPT1       16'h0081
`define OBC_ADDR_RSV0       16'h0082
`define OBC_ADDR_RSV1       16'h0083
`define OBC_ADDR_DBG        16'h0084
`define OBC_MIRROR_OFS      16'h1000
`define OBC_NUM_BYTES       5

// ----------------------------------------------------------------
// Field positions and values
// ----------------------------------------------------------------
`define OBC_POC_BIT         0
`define OBC_POC_DEFAULT     1'b0
`define OBC_DBG_OFF         8'h00
`define OBC_DBG_EN_A        8'h02
`define OBC_DBG_EN_B        8'h03
`define OBC_RESET_BYTE      8'h00

`endif

// ===== inc/obc_pkg.sv
// Types of the option-byte configuration loader
package obc_pkg;
    typedef enum logic [2:0] {
        OBC_IDLE,
        OBC_REQ,
        OBC_WAIT,
        OBC_FIX,
        OBC_DONE
    } obc_state_t;

    typedef logic [7:0] obc_byte_t;
endpackage : obc_pkg

// ===== inc/obc_flash_if.sv
// Flash read channel between the loader sequencer and the fetch unit
`timescale 1ns/100ps
interface obc_flash_if;
    logic        req;
    logic [15:0] addr;
    logic        ack;
    logic [7:0]  data;

    modport seq (output req, output addr, input ack, input data);
    modport fetch (input req, input addr, output ack, output data);
endinterface : obc_flash_if

// ===== design/obc_fetch.sv
// Fetch unit: passes one read request to the flash pins and returns the byte
`timescale 1ns/100ps
`include "obc_defines.svh"
module obc_fetch
    import obc_pkg::*;
(
    input  wire logic  clk,
    input  wire logic  rst_n,
    obc_flash_if.fetch fl,
    output logic       pin_req,
    output logic [15:0] pin_addr,
    input  wire logic  pin_ack,
    input  wire logic [7:0] pin_data
);
    logic        req_d, req_q;
    logic [15:0] addr_d, addr_q;
    logic        ack_d, ack_q;
    obc_byte_t   data_d, data_q;

    // ----------------------------------------------------------------
    // Request held until flash answers; answer registered as a pulse
    // ----------------------------------------------------------------
    always_comb begin
        // The loader strobes for one cycle only; the request stays up here so a slow array is never dropped
        req_d  = req_q ? ~pin_ack : fl.req;
        addr_d = (fl.req && !req_q) ? fl.addr : addr_q;
        ack_d  = req_q & pin_ack;
        data_d = (req_q && pin_ack) ? pin_data : data_q;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            req_q  <= 1'b0;
            addr_q <= 16'h0000;
            ack_q  <= 1'b0;
            data_q <= `OBC_RESET_BYTE;
        end else begin
            req_q  <= req_d;
            addr_q <= addr_d;
            ack_q  <= ack_d;
            data_q <= data_d;
        end
    end

    assign fl.ack  = ack_q;
    assign fl.data = data_q;
    assign pin_req  = req_q;
    assign pin_addr = addr_q;
endmodule : obc_fetch

// ===== design/obc_loader.sv
// Option-byte loader top: reads option bytes after reset and holds the configuration
`timescale 1ns/100ps
`include "obc_defines.svh"
module obc_loader
    import obc_pkg::*;
(
    input  wire logic        CLOCK,
    input  wire logic        NRST,
    input  wire logic        BOOT_SWAP,
    input  wire logic        EXT_PROGRAMMER,
    input  wire logic        DEBUG_CAPABLE,
    output logic             FLASH_REQ,
    output logic [15:0]      FLASH_ADDR,
    input  wire logic        FLASH_ACK,
    input  wire logic [7:0]  FLASH_DATA,
    output logic [7:0]       OPT_BYTE0,
    output logic [7:0]       OPT_BYTE1,
    output logic             POWER_ON_CLEAR_LEVEL_SELECT,
    output logic             DEBUG_ENABLE,
    output logic             RESERVED_NONZERO,
    output logic             LOAD_DONE,
    output logic             CPU_RUN
);
    obc_flash_if fl();

    obc_state_t  st_d, st_q;
    logic [2:0]  idx_d, idx_q;
    logic        swap_d, swap_q;
    logic        extp_d, extp_q;
    logic        dbgc_d, dbgc_q;
    obc_byte_t   ob_d [`OBC_NUM_BYTES];
    obc_byte_t   ob_q [`OBC_NUM_BYTES];
    logic [7:0]  o0_d, o0_q, o1_d, o1_q;
    logic        poc_d, poc_q, dbg_d, dbg_q, rsv_d, rsv_q;
    logic        done_d, done_q, req_d, req_q;
    logic [15:0] base;
    logic [`OBC_NUM_BYTES-1:0] slot_hit;

    // ----------------------------------------------------------------
    // Flash fetch
    // ----------------------------------------------------------------
    obc_fetch u_fetch (
        .clk      (CLOCK),
        .rst_n    (NRST),
        .fl       (fl.fetch),
        .pin_req  (FLASH_REQ),
        .pin_addr (FLASH_ADDR),
        .pin_ack  (FLASH_ACK),
        .pin_data (FLASH_DATA)
    );

    // Every slot is read from the mirror bank while a swap is strapped, so the
    // mirror first and debug bytes replace the primaries and the mirror second
    // byte lands in the primary second slot
    assign base    = `OBC_ADDR_OPT0 + {13'h0000, idx_q};
    assign fl.req  = req_q;
    assign fl.addr = swap_q ? (base + `OBC_MIRROR_OFS) : base;

    // ----------------------------------------------------------------
    // Strap capture
    // ----------------------------------------------------------------
    // Straps are caught by the first clock after release, never by the reset itself,
    // so a strap that settles late inside reset is still seen
    always_comb begin
        swap_d = swap_q;
        extp_d = extp_q;
        dbgc_d = dbgc_q;
        if (st_q == OBC_IDLE) begin
            swap_d = BOOT_SWAP;
            extp_d = EXT_PROGRAMMER;
            dbgc_d = DEBUG_CAPABLE;
        end
    end

    // Strap registers
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            swap_q <= 1'b0;
            extp_q <= 1'b0;
            dbgc_q <= 1'b0;
        end else begin
            swap_q <= swap_d;
            extp_q <= extp_d;
            dbgc_q <= dbgc_d;
        end
    end

    // ----------------------------------------------------------------
    // Load sequencer
    // ----------------------------------------------------------------
    // One read in flight at a time; the fetch unit holds it until the flash answers
    always_comb begin
        st_d  = st_q;
        idx_d = idx_q;
        req_d = 1'b0;
        case (st_q)
            OBC_IDLE: begin
                // Always start from the first option byte
                idx_d = 3'd0;
                st_d  = OBC_REQ;
            end
            OBC_REQ: begin
                // Single-cycle strobe; the fetch unit turns it into a held request
                req_d = 1'b1;
                st_d  = OBC_WAIT;
            end
            OBC_WAIT: begin
                // Nothing moves until the fetch unit hands back the byte
                if (fl.ack) begin
                    if (idx_q == 3'(`OBC_NUM_BYTES - 1)) begin
                        st_d = OBC_FIX;
                    end else begin
                        idx_d = idx_q + 3'd1;
                        st_d  = OBC_REQ;
                    end
                end
            end
            OBC_FIX: begin
                st_d = OBC_DONE;
            end
            OBC_DONE: begin
                // No way out but reset, so nothing can reload behind the processor
                st_d = OBC_DONE;
            end
            default: begin
                st_d = OBC_IDLE;
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            st_q  <= OBC_IDLE;
            idx_q <= 3'd0;
            req_q <= 1'b0;
        end else begin
            st_q  <= st_d;
            idx_q <= idx_d;
            req_q <= req_d;
        end
    end

    // ----------------------------------------------------------------
    // Option byte slots
    // ----------------------------------------------------------------
    // A slot only opens in the acknowledge cycle of its own read
    for (genvar g = 0; g < `OBC_NUM_BYTES; g++) begin : g_slot
        assign slot_hit[g] = (st_q == OBC_WAIT) && fl.ack && (idx_q == 3'(g));
        assign ob_d[g]     = slot_hit[g] ? fl.data : ob_q[g];
    end

    // ----------------------------------------------------------------
    // Configuration decode
    // ----------------------------------------------------------------
    // Outputs move only in the one fix-up cycle and then stand until reset
    always_comb begin
        o0_d   = o0_q;
        o1_d   = o1_q;
        poc_d  = poc_q;
        dbg_d  = dbg_q;
        rsv_d  = rsv_q;
        done_d = done_q;
        if (st_q == OBC_FIX) begin
            // Slots already hold the mirror copies when a swap was strapped
            o0_d = ob_q[0];
            o1_d = ob_q[1];
            // A self-programmed swap cannot move the clear level; default stays in force
            if (extp_q) begin
                poc_d = ob_q[1][`OBC_POC_BIT];
            end else begin
                poc_d              = `OBC_POC_DEFAULT;
                o1_d[`OBC_POC_BIT] = `OBC_POC_DEFAULT;
            end
            // Any code but the two enable values leaves debug off
            dbg_d  = dbgc_q && ((ob_q[4] == `OBC_DBG_EN_A) || (ob_q[4] == `OBC_DBG_EN_B));
            // Flag only; a bad reserved byte is the programmer's fault and is not blocked
            rsv_d  = (ob_q[2] != `OBC_RESET_BYTE) || (ob_q[3] != `OBC_RESET_BYTE);
            done_d = 1'b1;
        end
    end

    // Slots and configuration share one register block; only reset clears them
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            o0_q   <= `OBC_RESET_BYTE;
            o1_q   <= `OBC_RESET_BYTE;
            poc_q  <= `OBC_POC_DEFAULT;
            dbg_q  <= 1'b0;
            rsv_q  <= 1'b0;
            done_q <= 1'b0;
            for (int i = 0; i < `OBC_NUM_BYTES; i++) begin
                ob_q[i] <= `OBC_RESET_BYTE;
            end
        end else begin
            o0_q   <= o0_d;
            o1_q   <= o1_d;
            poc_q  <= poc_d;
            dbg_q  <= dbg_d;
            rsv_q  <= rsv_d;
            done_q <= done_d;
            for (int i = 0; i < `OBC_NUM_BYTES; i++) begin
                ob_q[i] <= ob_d[i];
            end
        end
    end

    // ----------------------------------------------------------------
    // Outputs, all registered and held until next reset
    // ----------------------------------------------------------------
    assign OPT_BYTE0                   = o0_q;
    assign OPT_BYTE1                   = o1_q;
    assign POWER_ON_CLEAR_LEVEL_SELECT = poc_q;
    assign DEBUG_ENABLE                = dbg_q;
    assign RESERVED_NONZERO            = rsv_q;
    assign LOAD_DONE                   = done_q;
    assign CPU_RUN                     = done_q;
endmodule : obc_loader

// ===== test/obc_loader_properties.sv
// Port checker for the option-byte loader
`timescale 1ns/100ps
module obc_loader_props (
    input wire logic        CLOCK,
    input wire logic        NRST,
    input wire logic        BOOT_SWAP,
    input wire logic        EXT_PROGRAMMER,
    input wire logic        DEBUG_CAPABLE,
    input wire logic        FLASH_REQ,
    input wire logic [15:0] FLASH_ADDR,
    input wire logic        FLASH_ACK,
    input wire logic [7:0]  FLASH_DATA,
    input wire logic [7:0]  OPT_BYTE0,
    input wire logic [7:0]  OPT_BYTE1,
    input wire logic        POWER_ON_CLEAR_LEVEL_SELECT,
    input wire logic        DEBUG_ENABLE,
    input wire logic        LOAD_DONE,
    input wire logic        CPU_RUN
);
    // ----------------------------------------
    // Debug byte as delivered by the flash
    // ----------------------------------------
    logic [7:0] dbg_d;
    logic [7:0] dbg_q;
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!NRST);
    // Catch the debug byte at its acknowledge
    always_comb begin
        dbg_d = dbg_q;
        if (FLASH_REQ && FLASH_ACK && FLASH_ADDR[7:0] == 8'h84) dbg_d = FLASH_DATA;
    end
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) dbg_q <= 8'h00;
        else dbg_q <= dbg_d;
    end
    req_hold_a: assert property (FLASH_REQ && !FLASH_ACK |=> FLASH_REQ && $stable(FLASH_ADDR))
        else $error("request dropped before ack");
    req_bound_a: assert property (FLASH_REQ |-> ##[1:40] !FLASH_REQ)
        else $error("request never ends");
    swap_bank_a: assert property (FLASH_REQ |-> FLASH_ADDR[12] == BOOT_SWAP)
        else $error("wrong flash bank");
    clear_lock_a: assert property (LOAD_DONE && !EXT_PROGRAMMER |-> !POWER_ON_CLEAR_LEVEL_SELECT)
        else $error("clear level taken without programmer");
    clear_bit_a: assert property (LOAD_DONE |-> POWER_ON_CLEAR_LEVEL_SELECT == OPT_BYTE1[0])
        else $error("clear level differs from byte bit");
    debug_code_a: assert property (LOAD_DONE |-> DEBUG_ENABLE == (DEBUG_CAPABLE && dbg_q inside {8'h02, 8'h03}))
        else $error("debug enable wrong");
    config_held_a: assert property (LOAD_DONE |=> LOAD_DONE && $stable(OPT_BYTE0) && $stable(OPT_BYTE1))
        else $error("configuration changed after load");
    run_after_a: assert property (CPU_RUN |-> LOAD_DONE && !FLASH_REQ)
        else $error("processor runs before load");
endmodule : obc_loader_props

bind obc_loader obc_loader_props i_obc_loader_props (.CLOCK(CLOCK), .NRST(NRST), .BOOT_SWAP(BOOT_SWAP),
    .EXT_PROGRAMMER(EXT_PROGRAMMER), .DEBUG_CAPABLE(DEBUG_CAPABLE), .FLASH_REQ(FLASH_REQ),
    .FLASH_ADDR(FLASH_ADDR), .FLASH_ACK(FLASH_ACK), .FLASH_DATA(FLASH_DATA), .OPT_BYTE0(OPT_BYTE0),
    .OPT_BYTE1(OPT_BYTE1), .POWER_ON_CLEAR_LEVEL_SELECT(POWER_ON_CLEAR_LEVEL_SELECT),
    .DEBUG_ENABLE(DEBUG_ENABLE), .LOAD_DONE(LOAD_DONE), .CPU_RUN(CPU_RUN));

// ===== test/obc_flash_model.sv
// Flash array model answering the loader's byte reads
`timescale 1ns/100ps
module obc_flash_model (
    input wire logic        clk,
    input wire logic        req,
    input wire logic [15:0] addr,
    input wire logic        slow,
    output logic            ack,
    output logic [7:0]      data
);
    // ----------------------------------------
    // Array and answer
    // ----------------------------------------
    logic [7:0] mem [logic [15:0]];
    int         wait_n = 0;
    initial begin
        ack = 1'b0;
        data = 8'h00;
    end
    // One byte per request; data turns over once the ack cycle ends
    always @(posedge clk) begin
        if (ack) begin
            ack <= 1'b0;
            data <= ~data;
        end else if (req && slow && wait_n < 3) wait_n <= wait_n + 1;
        else if (req) begin
            ack <= 1'b1;
            data <= mem.exists(addr) ? mem[addr] : 8'h00;
            wait_n <= 0;
        end
    end
endmodule : obc_flash_model

// ===== test/obc_loader_test.sv
// Self-checking bench for the option-byte loader
`timescale 1ns/100ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin bad_count++; \
    $display("BAD %s exp %h got %h", n, e, g); end end
module obc_loader_test;
    logic CLOCK = 0, NRST = 0, BOOT_SWAP = 0, EXT_PROGRAMMER = 0, DEBUG_CAPABLE = 0, slow = 0;
    logic FLASH_REQ, FLASH_ACK, POC, DEBUG_ENABLE, RESERVED_NONZERO, LOAD_DONE, CPU_RUN;
    logic [15:0] FLASH_ADDR;
    logic [7:0]  FLASH_DATA, OPT_BYTE0, OPT_BYTE1;
    int          bad_count = 0;
    int          check_count = 0;
    always #5 CLOCK = ~CLOCK;
    obc_loader i_obc_loader (.CLOCK(CLOCK), .NRST(NRST), .BOOT_SWAP(BOOT_SWAP), .EXT_PROGRAMMER(EXT_PROGRAMMER),
        .DEBUG_CAPABLE(DEBUG_CAPABLE), .FLASH_REQ(FLASH_REQ), .FLASH_ADDR(FLASH_ADDR), .FLASH_ACK(FLASH_ACK),
        .FLASH_DATA(FLASH_DATA), .OPT_BYTE0(OPT_BYTE0), .OPT_BYTE1(OPT_BYTE1), .POWER_ON_CLEAR_LEVEL_SELECT(POC),
        .DEBUG_ENABLE(DEBUG_ENABLE), .RESERVED_NONZERO(RESERVED_NONZERO), .LOAD_DONE(LOAD_DONE), .CPU_RUN(CPU_RUN));
    obc_flash_model i_obc_flash_model (.clk(CLOCK), .req(FLASH_REQ), .addr(FLASH_ADDR), .slow(slow),
        .ack(FLASH_ACK), .data(FLASH_DATA));
    // ----------------------------------------
    // Shared steps
    // ----------------------------------------
    // Primary and mirror bytes; reserved places kept zero
    task automatic fill(input logic [7:0] p0, p1, p4, m0, m1, m4);
        foreach (i_obc_flash_model.mem[a]) i_obc_flash_model.mem[a] = 8'h00;
        i_obc_flash_model.mem[16'h0080] = p0;
        i_obc_flash_model.mem[16'h0081] = p1;
        i_obc_flash_model.mem[16'h0084] = p4;
        i_obc_flash_model.mem[16'h1080] = m0;
        i_obc_flash_model.mem[16'h1081] = m1;
        i_obc_flash_model.mem[16'h1084] = m4;
    endtask : fill
    // Straps are set inside reset so the first edge after release sees them
    task automatic load(input logic sw, ex, cap, sl);
        @(posedge CLOCK);
        NRST <= 1'b0;
        BOOT_SWAP <= sw;
        EXT_PROGRAMMER <= ex;
        DEBUG_CAPABLE <= cap;
        slow <= sl;
        repeat (4) @(posedge CLOCK);
        NRST <= 1'b1;
        for (int n = 0; n < 200 && LOAD_DONE !== 1'b1; n++) @(posedge CLOCK);
        `CHK("done", 1'b1, LOAD_DONE)
        `CHK("run", 1'b1, CPU_RUN)
    endtask : load
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_plain;
        fill(8'h5a, 8'h01, 8'h02, 8'ha5, 8'h00, 8'h00);
        load(1'b0, 1'b1, 1'b1, 1'b0);
        repeat (20) @(posedge CLOCK);
        `CHK("byte0", 8'h5a, OPT_BYTE0)
        `CHK("byte1", 8'h01, OPT_BYTE1)
        `CHK("clear", 1'b1, POC)
        `CHK("dbg", 1'b1, DEBUG_ENABLE)
        `CHK("rsv", 1'b0, RESERVED_NONZERO)
    endtask : t_plain
    // Mirrors differ on purpose so the exchange is visible
    task automatic t_swap;
        fill(8'h5a, 8'h00, 8'h00, 8'ha5, 8'h03, 8'h03);
        load(1'b1, 1'b0, 1'b1, 1'b1);
        `CHK("byte0", 8'ha5, OPT_BYTE0)
        `CHK("byte1", 8'h02, OPT_BYTE1)
        `CHK("clear", 1'b0, POC)
        `CHK("dbg", 1'b1, DEBUG_ENABLE)
    endtask : t_swap
    // Programmer keeps both banks equal, so a swap must not change the configuration
    task automatic t_mirror;
        fill(8'h3c, 8'h01, 8'h02, 8'h3c, 8'h01, 8'h02);
        load(1'b1, 1'b1, 1'b1, 1'b0);
        `CHK("byte0", 8'h3c, OPT_BYTE0)
        `CHK("byte1", 8'h01, OPT_BYTE1)
        `CHK("clear", 1'b1, POC)
        `CHK("dbg", 1'b1, DEBUG_ENABLE)
        `CHK("rsv", 1'b0, RESERVED_NONZERO)
    endtask : t_mirror
    task automatic t_codes;
        logic [7:0] codes[6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'hff};
        foreach (codes[k]) begin
            fill(8'h11, 8'h00, codes[k], 8'h11, 8'h00, codes[k]);
            load(1'b0, 1'b1, 1'b1, 1'b0);
            `CHK("code", codes[k] inside {8'h02, 8'h03}, DEBUG_ENABLE)
        end
        load(1'b0, 1'b1, 1'b0, 1'b1);
        `CHK("nodbg", 1'b0, DEBUG_ENABLE)
    endtask : t_codes
    task automatic t_rsv;
        fill(8'h11, 8'h00, 8'h00, 8'h11, 8'h00, 8'h00);
        i_obc_flash_model.mem[16'h0083] = 8'h01;
        load(1'b0, 1'b1, 1'b1, 1'b0);
        `CHK("rsv", 1'b1, RESERVED_NONZERO)
    endtask : t_rsv
    task automatic summarize;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : summarize
    initial begin
        t_plain();
        t_swap();
        t_mirror();
        t_codes();
        t_rsv();
        summarize();
    end
    // Whole run needs a few hundred cycles at most
    initial begin
        #200000;
        bad_count++;
        summarize();
    end
endmodule : obc_loader_test
